// file: dual_timer_pkg.sv
package dual_timer_pkg;

    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int HALF_W     = 16;
    localparam int FULL_W     = 32;
    localparam int NUM_HALVES = 2;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_CFG     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CTL     = 8'h04;
    localparam logic [ADDR_W-1:0] REG_LOAD_A  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_LOAD_B  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_MATCH_A = 8'h10;
    localparam logic [ADDR_W-1:0] REG_MATCH_B = 8'h14;
    localparam logic [ADDR_W-1:0] REG_VALUE_A = 8'h18;
    localparam logic [ADDR_W-1:0] REG_VALUE_B = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_IMR     = 8'h20;
    localparam logic [ADDR_W-1:0] REG_RIS     = 8'h24;
    localparam logic [ADDR_W-1:0] REG_MIS     = 8'h28;
    localparam logic [ADDR_W-1:0] REG_ICR     = 8'h2C;

    // mode_selection register
    localparam int CFG_W        = 11;
    localparam int CFG_JOIN_LSB = 0;
    localparam int CFG_JOIN_W   = 3;
    localparam int CFG_HALF_LSB = 3;
    localparam int CFG_HALF_W   = 4;
    localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;

    localparam logic [CFG_JOIN_W-1:0] JOIN_OS_DN  = 3'h0;
    localparam logic [CFG_JOIN_W-1:0] JOIN_OS_UP  = 3'h1;
    localparam logic [CFG_JOIN_W-1:0] JOIN_PER_DN = 3'h2;
    localparam logic [CFG_JOIN_W-1:0] JOIN_PER_UP = 3'h3;
    localparam logic [CFG_JOIN_W-1:0] JOIN_RTC    = 3'h4;
    localparam logic [CFG_JOIN_W-1:0] JOIN_PAIR   = 3'h5;

    localparam logic [CFG_HALF_W-1:0] HM_OS_DN  = 4'h0;
    localparam logic [CFG_HALF_W-1:0] HM_OS_UP  = 4'h1;
    localparam logic [CFG_HALF_W-1:0] HM_PER_DN = 4'h2;
    localparam logic [CFG_HALF_W-1:0] HM_PER_UP = 4'h3;
    localparam logic [CFG_HALF_W-1:0] HM_CNT_DN = 4'h4;
    localparam logic [CFG_HALF_W-1:0] HM_CNT_UP = 4'h5;
    localparam logic [CFG_HALF_W-1:0] HM_TIM_DN = 4'h6;
    localparam logic [CFG_HALF_W-1:0] HM_TIM_UP = 4'h7;
    localparam logic [CFG_HALF_W-1:0] HM_PWM    = 4'h8;

    // control register, one byte per half
    localparam int CTL_W      = 16;
    localparam int CTL_STRIDE = 8;
    localparam int CTL_EN     = 0;
    localparam int CTL_STALL  = 1;
    localparam int CTL_TRIG   = 2;
    localparam int CTL_POL    = 3;
    localparam int CTL_WAIT   = 4;
    localparam int CTL_EDGE   = 5;
    localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;

    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // interrupt bits, second half sits INT_STRIDE above the first
    localparam int INT_W      = 7;
    localparam int INT_STRIDE = 4;
    localparam int INT_TMO    = 0;
    localparam int INT_CMT    = 1;
    localparam int INT_CEV    = 2;
    localparam int INT_RTC    = 3;
    localparam logic [INT_W-1:0] IMR_RESET = 7'h00;

    localparam logic [FULL_W-1:0] LOAD_RESET  = 32'h00000000;
    localparam logic [FULL_W-1:0] MATCH_RESET = 32'h00000000;
    localparam logic [FULL_W-1:0] HALF_MAX    = 32'h0000FFFF;

    // rtc: external source edges per second tick
    localparam int RTC_SRC_HZ = 32768;
    localparam int RTC_TICK_S = 1;
    localparam int RTC_DIV    = RTC_SRC_HZ * RTC_TICK_S;

    // synchroniser lanes
    localparam int SYNC_W   = 6;
    localparam int SY_CAP   = 0;
    localparam int SY_RTC   = 2;
    localparam int SY_DBG   = 3;
    localparam int SY_CHAIN = 4;

    typedef enum logic [3:0] {
        UM_OS_DN, UM_OS_UP, UM_PER_DN, UM_PER_UP, UM_CNT_DN,
        UM_CNT_UP, UM_TIM_DN, UM_TIM_UP, UM_PWM, UM_RTC
    } unit_mode_t;

    typedef struct packed {
        logic timeout;
        logic cap_evt;
        logic cap_match;
    } unit_evt_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

endpackage

// file: count_unit.sv
`timescale 1ns/1ns
module count_unit #(
    parameter int W = 32
) (
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    run,
    input  wire logic                    tick,
    input  wire logic                    restart,
    input  wire dual_timer_pkg::unit_mode_t mode,
    input  wire logic                    narrow,
    input  wire logic [W-1:0]            load_val,
    input  wire logic                    load_wr,
    input  wire logic [W-1:0]            match_val,
    input  wire logic                    edge_evt,
    output logic [W-1:0]                 count,
    output logic [W-1:0]                 captured,
    output dual_timer_pkg::unit_evt_t    evt,
    output logic                         pwm
);
    import dual_timer_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] cap;
        logic         done;
        logic         pwm;
        unit_evt_t    evt;
    } unit_state_t;

    unit_state_t s_ff;
    unit_state_t nxt_s;
    logic [W-1:0] mask;
    logic [W-1:0] lim_load;
    logic [W-1:0] lim_match;
    logic [W-1:0] dn;
    logic [W-1:0] up;

    always_comb begin
        nxt_s     = s_ff;
        nxt_s.evt = '0;
        // a joined counter still obeys the 16-bit span when split
        mask      = narrow ? W'(HALF_MAX) : '1;
        lim_load  = load_val & mask;
        lim_match = match_val & mask;
        dn        = (s_ff.cnt - W'(1)) & mask;
        up        = (s_ff.cnt + W'(1)) & mask;
        if (restart) begin
            nxt_s.done = 1'b0;
        end
        if (load_wr) begin
            nxt_s.cnt  = lim_load;
            nxt_s.done = 1'b0;
        end else if (run) begin
            unique case (mode)
                UM_OS_DN, UM_PER_DN, UM_PWM: begin
                    if (tick && !s_ff.done) begin
                        if (s_ff.cnt == '0) begin
                            nxt_s.evt.timeout = 1'b1;
                            if (mode == UM_OS_DN) begin
                                nxt_s.done = 1'b1;
                            end else begin
                                nxt_s.cnt = lim_load;
                            end
                        end else begin
                            nxt_s.cnt = dn;
                        end
                    end
                end
                UM_OS_UP, UM_PER_UP: begin
                    if (tick && !s_ff.done) begin
                        if (s_ff.cnt == lim_load) begin
                            nxt_s.evt.timeout = 1'b1;
                            if (mode == UM_OS_UP) begin
                                nxt_s.done = 1'b1;
                            end else begin
                                nxt_s.cnt = '0;
                            end
                        end else begin
                            nxt_s.cnt = up;
                        end
                    end
                end
                UM_CNT_DN, UM_CNT_UP: begin
                    if (edge_evt) begin
                        nxt_s.evt.cap_evt = 1'b1;
                        nxt_s.cnt = (mode == UM_CNT_DN) ? dn : up;
                        if (nxt_s.cnt == lim_match) begin
                            nxt_s.evt.cap_match = 1'b1;
                            nxt_s.cnt = (mode == UM_CNT_DN) ? lim_load : '0;
                        end
                    end
                end
                UM_TIM_DN, UM_TIM_UP: begin
                    if (tick) begin
                        if (mode == UM_TIM_DN) begin
                            nxt_s.cnt = (s_ff.cnt == '0) ? lim_load : dn;
                        end else begin
                            nxt_s.cnt = (s_ff.cnt == lim_load) ? '0 : up;
                        end
                    end
                    if (edge_evt) begin
                        nxt_s.cap         = s_ff.cnt;
                        nxt_s.evt.cap_evt = 1'b1;
                    end
                end
                UM_RTC: begin
                    if (tick) begin
                        nxt_s.cnt = up;
                        nxt_s.evt.cap_match = (up == lim_match);
                    end
                end
            endcase
        end
        // edge aligned: active from reload until the count falls to match
        nxt_s.pwm = (mode == UM_PWM) && (nxt_s.cnt > lim_match);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign count    = s_ff.cnt;
    assign captured = s_ff.cap;
    assign evt      = s_ff.evt;
    assign pwm      = s_ff.pwm;

endmodule // count_unit

// file: dual_half_gp_timer.sv
`timescale 1ns/1ns
module dual_half_gp_timer #(
    parameter int RTC_DIV_P = dual_timer_pkg::RTC_DIV
) (
    input  wire logic                                 clock,
    input  wire logic                                 nrst,
    input  wire dual_timer_pkg::bus_req_t             bus_req,
    output logic [dual_timer_pkg::DATA_W-1:0]         rdata,
    input  wire logic [dual_timer_pkg::NUM_HALVES-1:0] cap_in,
    output logic [dual_timer_pkg::NUM_HALVES-1:0]     cap_out,
    output logic [dual_timer_pkg::NUM_HALVES-1:0]     cap_oe_n,
    input  wire logic                                 rtc_clk_in,
    input  wire logic                                 debug_halt,
    input  wire logic [dual_timer_pkg::NUM_HALVES-1:0] chain_trig_in,
    output logic [dual_timer_pkg::NUM_HALVES-1:0]     trig_out,
    output logic                                      irq
);
    import dual_timer_pkg::*;

    localparam int DIV_W = $clog2(RTC_DIV_P);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIV_P - 1);

    typedef struct packed {
        logic [CFG_W-1:0]      cfg;
        logic [CTL_W-1:0]      ctl;
        logic [FULL_W-1:0]     load_a;
        logic [HALF_W-1:0]     load_b;
        logic [FULL_W-1:0]     match_a;
        logic [HALF_W-1:0]     match_b;
        logic [INT_W-1:0]      imr;
        logic [INT_W-1:0]      ris;
        logic [DATA_W-1:0]     rdata;
        logic [SYNC_W-1:0]     sync1;
        logic [SYNC_W-1:0]     sync2;
        logic [SYNC_W-1:0]     sync3;
        logic [NUM_HALVES-1:0] en_prev;
        logic [NUM_HALVES-1:0] armed;
        logic [DIV_W-1:0]      rtc_div;
        logic                  rtc_tick;
        logic [NUM_HALVES-1:0] trig;
        logic [NUM_HALVES-1:0] pin_out;
        logic [NUM_HALVES-1:0] pin_oe_n;
        logic                  irq;
    } top_state_t;

    top_state_t s_ff;
    top_state_t nxt_s;

    logic                  joined;
    logic                  rtc_mode;
    logic [NUM_HALVES-1:0] run;
    logic [NUM_HALVES-1:0] restart;
    logic [NUM_HALVES-1:0] edge_evt;
    logic [NUM_HALVES-1:0] load_wr;
    logic [NUM_HALVES-1:0] pwm;
    logic [NUM_HALVES-1:0] is_pwm;
    logic [NUM_HALVES-1:0] is_time;
    logic [INT_W-1:0]      int_set;
    logic [INT_W-1:0]      int_clr;
    logic [SYNC_W-1:0]     rise;
    logic [SYNC_W-1:0]     fall;
    logic                  tick_a;
    unit_mode_t            mode [NUM_HALVES];
    unit_evt_t             evt [NUM_HALVES];
    logic [FULL_W-1:0]     cnt_a;
    logic [FULL_W-1:0]     cap_a;
    logic [HALF_W-1:0]     cnt_b;
    logic [HALF_W-1:0]     cap_b;

    function automatic unit_mode_t half_mode(input logic [CFG_HALF_W-1:0] code);
        unit_mode_t m;
        case (code)
            HM_OS_DN:  m = UM_OS_DN;
            HM_OS_UP:  m = UM_OS_UP;
            HM_PER_DN: m = UM_PER_DN;
            HM_PER_UP: m = UM_PER_UP;
            HM_CNT_DN: m = UM_CNT_DN;
            HM_CNT_UP: m = UM_CNT_UP;
            HM_TIM_DN: m = UM_TIM_DN;
            HM_TIM_UP: m = UM_TIM_UP;
            HM_PWM:    m = UM_PWM;
            default:   m = UM_OS_DN;
        endcase
        return m;
    endfunction

    function automatic unit_mode_t join_mode(input logic [CFG_JOIN_W-1:0] code);
        unit_mode_t m;
        case (code)
            JOIN_OS_UP:  m = UM_OS_UP;
            JOIN_PER_DN: m = UM_PER_DN;
            JOIN_PER_UP: m = UM_PER_UP;
            JOIN_RTC:    m = UM_RTC;
            default:     m = UM_OS_DN;
        endcase
        return m;
    endfunction

    always_comb begin
        nxt_s    = s_ff;
        joined   = s_ff.cfg[CFG_JOIN_LSB +: CFG_JOIN_W] != JOIN_PAIR;
        rtc_mode = s_ff.cfg[CFG_JOIN_LSB +: CFG_JOIN_W] == JOIN_RTC;
        // only the second stage and its delayed copy feed any logic
        nxt_s.sync1 = {chain_trig_in, debug_halt, rtc_clk_in, cap_in};
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.sync3 = s_ff.sync2;
        rise = s_ff.sync2 & ~s_ff.sync3;
        fall = ~s_ff.sync2 & s_ff.sync3;

        mode[0] = joined ? join_mode(s_ff.cfg[CFG_JOIN_LSB +: CFG_JOIN_W])
                         : half_mode(s_ff.cfg[CFG_HALF_LSB +: CFG_HALF_W]);
        mode[1] = half_mode(s_ff.cfg[CFG_HALF_LSB + CFG_HALF_W +: CFG_HALF_W]);

        load_wr[0] = bus_req.wr && bus_req.addr == REG_LOAD_A;
        load_wr[1] = bus_req.wr && bus_req.addr == REG_LOAD_B;
        int_set    = '0;
        int_clr    = (bus_req.wr && bus_req.addr == REG_ICR) ? bus_req.wdata[INT_W-1:0] : '0;

        for (int h = 0; h < NUM_HALVES; h++) begin
            logic en;
            logic [1:0] esel;
            logic       stall_en;
            logic       trig_en;
            logic       pol_low;
            logic       wait_en;
            en       = s_ff.ctl[h*CTL_STRIDE + CTL_EN];
            esel     = s_ff.ctl[h*CTL_STRIDE + CTL_EDGE +: 2];
            stall_en = s_ff.ctl[h*CTL_STRIDE + CTL_STALL];
            trig_en  = s_ff.ctl[h*CTL_STRIDE + CTL_TRIG];
            pol_low  = s_ff.ctl[h*CTL_STRIDE + CTL_POL];
            wait_en  = s_ff.ctl[h*CTL_STRIDE + CTL_WAIT];
            // the second half is idle while the pair acts as one counter
            if (h == 1 && joined) begin
                en = 1'b0;
            end
            if (!en) begin
                nxt_s.armed[h] = 1'b0;
            end else if (rise[SY_CHAIN + h]) begin
                nxt_s.armed[h] = 1'b1;
            end
            run[h] = en
                && !(stall_en && s_ff.sync2[SY_DBG])
                && (!wait_en || s_ff.armed[h]);
            restart[h]       = en && !s_ff.en_prev[h];
            nxt_s.en_prev[h] = en;
            is_pwm[h]  = !joined && mode[h] == UM_PWM;
            is_time[h] = mode[h] == UM_TIM_DN || mode[h] == UM_TIM_UP;
            unique case (esel)
                EDGE_RISE: edge_evt[h] = rise[SY_CAP + h];
                EDGE_FALL: edge_evt[h] = fall[SY_CAP + h];
                EDGE_BOTH: edge_evt[h] = rise[SY_CAP + h] || fall[SY_CAP + h];
                default:   edge_evt[h] = 1'b0;
            endcase
            edge_evt[h] = edge_evt[h] && !joined && !is_pwm[h];
            int_set[h*INT_STRIDE + INT_TMO] = evt[h].timeout;
            int_set[h*INT_STRIDE + INT_CEV] = evt[h].cap_evt;
            int_set[h*INT_STRIDE + INT_CMT] = evt[h].cap_match && !(h == 0 && rtc_mode);
            nxt_s.trig[h]     = evt[h].timeout && trig_en;
            nxt_s.pin_out[h]  = is_pwm[h] && (pwm[h] ^ pol_low);
            nxt_s.pin_oe_n[h] = !is_pwm[h];
        end
        // rtc match rides on the first unit's match pulse
        int_set[INT_RTC] = rtc_mode && evt[0].cap_match;

        // rtc prescale counts edges of the external source, not system clocks
        nxt_s.rtc_tick = 1'b0;
        if (!rtc_mode) begin
            nxt_s.rtc_div = '0;
        end else if (run[0] && rise[SY_RTC]) begin
            if (s_ff.rtc_div == DIV_LAST) begin
                nxt_s.rtc_div  = '0;
                nxt_s.rtc_tick = 1'b1;
            end else begin
                nxt_s.rtc_div = s_ff.rtc_div + DIV_W'(1);
            end
        end
        // outside rtc the counter steps every clock; there is no prescaler
        tick_a = rtc_mode ? s_ff.rtc_tick : 1'b1;

        // a fresh event beats a clear in the same cycle
        nxt_s.ris = (s_ff.ris & ~int_clr) | int_set;
        nxt_s.irq = |(nxt_s.ris & nxt_s.imr);

        if (bus_req.wr) begin
            unique case (bus_req.addr)
                REG_CFG:     nxt_s.cfg = bus_req.wdata[CFG_W-1:0];
                REG_CTL:     nxt_s.ctl = bus_req.wdata[CTL_W-1:0];
                REG_LOAD_A:  nxt_s.load_a = bus_req.wdata;
                REG_LOAD_B:  nxt_s.load_b = bus_req.wdata[HALF_W-1:0];
                REG_MATCH_A: nxt_s.match_a = bus_req.wdata;
                REG_MATCH_B: nxt_s.match_b = bus_req.wdata[HALF_W-1:0];
                REG_IMR:     nxt_s.imr = bus_req.wdata[INT_W-1:0];
                default:     nxt_s.cfg = s_ff.cfg;
            endcase
        end

        nxt_s.rdata = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                REG_CFG:     nxt_s.rdata = DATA_W'(s_ff.cfg);
                REG_CTL:     nxt_s.rdata = DATA_W'(s_ff.ctl);
                REG_LOAD_A:  nxt_s.rdata = s_ff.load_a;
                REG_LOAD_B:  nxt_s.rdata = DATA_W'(s_ff.load_b);
                REG_MATCH_A: nxt_s.rdata = s_ff.match_a;
                REG_MATCH_B: nxt_s.rdata = DATA_W'(s_ff.match_b);
                // edge-time halves report the latched capture, not the running count
                REG_VALUE_A: nxt_s.rdata = is_time[0] ? cap_a : cnt_a;
                REG_VALUE_B: nxt_s.rdata = DATA_W'(is_time[1] ? cap_b : cnt_b);
                REG_IMR:     nxt_s.rdata = DATA_W'(s_ff.imr);
                REG_RIS:     nxt_s.rdata = DATA_W'(s_ff.ris);
                REG_MIS:     nxt_s.rdata = DATA_W'(s_ff.ris & s_ff.imr);
                default:     nxt_s.rdata = '0;
            endcase
        end
    end

    // reset leaves both pins undriven until a half is put in pwm
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_ff          <= '0;
            s_ff.cfg      <= CFG_RESET;
            s_ff.ctl      <= CTL_RESET;
            s_ff.load_a   <= LOAD_RESET;
            s_ff.load_b   <= LOAD_RESET[HALF_W-1:0];
            s_ff.match_a  <= MATCH_RESET;
            s_ff.match_b  <= MATCH_RESET[HALF_W-1:0];
            s_ff.imr      <= IMR_RESET;
            s_ff.pin_oe_n <= '1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    count_unit #(.W(FULL_W)) unit_a (
        .clock     (clock),
        .nrst      (nrst),
        .run       (run[0]),
        .tick      (tick_a),
        .restart   (restart[0]),
        .mode      (mode[0]),
        .narrow    (!joined),
        // next-state copy, so a load write and its reload share one edge
        .load_val  (nxt_s.load_a),
        .load_wr   (load_wr[0]),
        .match_val (s_ff.match_a),
        .edge_evt  (edge_evt[0]),
        .count     (cnt_a),
        .captured  (cap_a),
        .evt       (evt[0]),
        .pwm       (pwm[0])
    );

    count_unit #(.W(HALF_W)) unit_b (
        .clock     (clock),
        .nrst      (nrst),
        .run       (run[1]),
        .tick      (1'b1),
        .restart   (restart[1]),
        .mode      (mode[1]),
        .narrow    (1'b1),
        .load_val  (nxt_s.load_b),
        .load_wr   (load_wr[1]),
        .match_val (s_ff.match_b),
        .edge_evt  (edge_evt[1]),
        .count     (cnt_b),
        .captured  (cap_b),
        .evt       (evt[1]),
        .pwm       (pwm[1])
    );

    assign rdata    = s_ff.rdata;
    assign cap_out  = s_ff.pin_out;
    assign cap_oe_n = s_ff.pin_oe_n;
    assign trig_out = s_ff.trig;
    assign irq      = s_ff.irq;

endmodule // dual_half_gp_timer

// file: dual_timer_checker.sv
`timescale 1ns/1ns
module dual_timer_checker (
    input wire logic                                      clock,
    input wire logic                                      nrst,
    input wire dual_timer_pkg::bus_req_t                  bus_req,
    input wire logic [dual_timer_pkg::DATA_W-1:0]         rdata,
    input wire logic [dual_timer_pkg::NUM_HALVES-1:0]     cap_out,
    input wire logic [dual_timer_pkg::NUM_HALVES-1:0]     cap_oe_n,
    input wire logic                                      irq
);
    import dual_timer_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence rd_of(logic [ADDR_W-1:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    sequence wr_of(logic [ADDR_W-1:0] a);
        bus_req.wr && bus_req.addr == a;
    endsequence
    chk_rdata_idle: assert property (!bus_req.rd |=> rdata == '0)
        else $error("read data not zero outside a read answer");
    chk_clear_reads_zero: assert property (rd_of(REG_ICR) |=> rdata == '0)
        else $error("clear register read not zero");
    chk_unmapped_zero: assert property (bus_req.rd && bus_req.addr > REG_ICR |=> rdata == '0)
        else $error("unmapped read not zero");
    chk_status_width: assert property (rd_of(REG_RIS) |=> rdata[DATA_W-1:INT_W] == '0)
        else $error("raw status upper bits not zero");
    chk_mode_width: assert property (rd_of(REG_CFG) |=> rdata[DATA_W-1:CFG_W] == '0)
        else $error("mode register upper bits not zero");
    chk_pin_parked: assert property ((cap_oe_n & cap_out) == '0)
        else $error("pin drive active while output disabled");
    // only a clear or a mask write may drop a pending request
    chk_irq_holds: assert property (irq && !(bus_req.wr && (bus_req.addr == REG_ICR || bus_req.addr == REG_IMR))
        |=> irq)
        else $error("interrupt dropped without clear");
    chk_joined_no_pwm: assert property (wr_of(REG_CFG) ##0 bus_req.wdata[2:0] != JOIN_PAIR
        |-> ##[1:3] cap_oe_n == 2'h3)
        else $error("pin still driven in joined mode");
endmodule // dual_timer_checker
bind dual_half_gp_timer dual_timer_checker dual_timer_checker_i (.clock(clock), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .cap_out(cap_out), .cap_oe_n(cap_oe_n), .irq(irq));

// file: dual_half_gp_timer_tb.sv
`timescale 1ns/1ns
module dual_half_gp_timer_tb;
    import dual_timer_pkg::*;
    logic        clock = 1'h0, nrst = 1'h0, rtc_clk_in = 1'h0, debug_halt = 1'h0, irq;
    logic [1:0]  cap_in = 2'h0, chain_trig_in = 2'h0, cap_out, cap_oe_n, trig_out;
    bus_req_t    bus_req = '0;
    logic [31:0] rdata, v, w;
    int          bad_count = 0, n_compared = 0, k;
    always #4 clock = ~clock;
    dual_half_gp_timer #(.RTC_DIV_P(4)) dual_half_gp_timer_i (.clock(clock), .nrst(nrst), .bus_req(bus_req),
        .rdata(rdata), .cap_in(cap_in), .cap_out(cap_out), .cap_oe_n(cap_oe_n), .rtc_clk_in(rtc_clk_in),
        .debug_halt(debug_halt), .chain_trig_in(chain_trig_in), .trig_out(trig_out), .irq(irq));
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'h1;
        @(posedge clock);
        bus_req.wr <= 1'h0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        bus_req.addr <= a;
        bus_req.rd <= 1'h1;
        @(posedge clock);
        bus_req.rd <= 1'h0;
        #1 v = rdata;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, v);
    endtask
    // counts high cycles of one output bit; trigger pulses are one cycle wide, pwm pin highs are longer
    task count_high(input int n, input int sel);
        k = 0;
        repeat (n) begin
            @(posedge clock);
            #1 k += (sel == 0) ? trig_out[0] : cap_out[1];
        end
    endtask
    task t_reset;
        rchk("mode", REG_CFG, 32'(CFG_RESET));
        rchk("control", REG_CTL, 32'(CTL_RESET));
        rchk("mask", REG_IMR, 32'(IMR_RESET));
        rchk("raw", REG_RIS, 32'h0);
        rchk("load", REG_LOAD_A, LOAD_RESET);
        rchk("unmapped", 8'h30, 32'h0);
        $display("test reset done");
    endtask
    task t_wait_oneshot;
        wr(REG_CFG, 32'h5);
        wr(REG_LOAD_A, 32'h3);
        wr(REG_IMR, 32'h1);
        wr(REG_CTL, 32'h15);
        repeat (10) @(posedge clock);
        rchk("held", REG_VALUE_A, 32'h3);
        chain_trig_in <= 2'h1;
        count_high(20, 0);
        chk("trigger pulses", 32'h1, k);
        rchk("stopped", REG_VALUE_A, 32'h0);
        chk("irq", 32'h1, irq);
        rchk("masked", REG_MIS, 32'h1);
        wr(REG_ICR, 32'h1);
        rchk("cleared", REG_RIS, 32'h0);
        chk("irq low", 32'h0, irq);
        wr(REG_CTL, 32'h0);
        chain_trig_in <= 2'h0;
        $display("test wait oneshot done");
    endtask
    task t_periodic;
        wr(REG_CFG, 32'h15);
        wr(REG_LOAD_A, 32'h3);
        wr(REG_CTL, 32'h5);
        repeat (8) @(posedge clock);
        count_high(40, 0);
        chk("period pulses", 32'hA, k);
        wr(REG_LOAD_A, 32'h10);
        rchk("reload", REG_VALUE_A, 32'h10);
        debug_halt <= 1'h1;
        wr(REG_CTL, 32'h7);
        repeat (6) @(posedge clock);
        rd(REG_VALUE_A);
        w = v;
        repeat (5) @(posedge clock);
        rchk("frozen", REG_VALUE_A, w);
        debug_halt <= 1'h0;
        wr(REG_CTL, 32'h0);
        wr(REG_ICR, 32'h7F);
        $display("test periodic done");
    endtask
    task t_pwm;
        wr(REG_CFG, 32'h405);
        wr(REG_LOAD_B, 32'h9);
        wr(REG_MATCH_B, 32'h2);
        wr(REG_CTL, 32'h900);
        repeat (8) @(posedge clock);
        chk("pin enable", 32'h1, cap_oe_n);
        count_high(20, 1);
        chk("inverted high", 32'h6, k);
        wr(REG_CTL, 32'h0);
        wr(REG_CFG, 32'h0);
        repeat (4) @(posedge clock);
        chk("joined pins", 32'h3, cap_oe_n);
        $display("test pwm done");
    endtask
    task t_capture;
        wr(REG_CFG, 32'h2D);
        wr(REG_LOAD_A, 32'h0);
        wr(REG_MATCH_A, 32'h3);
        wr(REG_IMR, 32'h2);
        wr(REG_CTL, 32'h21);
        for (int i = 0; i < 3; i++) begin
            cap_in <= 2'h1;
            repeat (4) @(posedge clock);
            cap_in <= 2'h0;
            repeat (6) @(posedge clock);
            if (i == 1) rchk("falling edges", REG_VALUE_A, 32'h2);
        end
        rd(REG_RIS);
        chk("count match", 32'h1, v[INT_CMT]);
        chk("irq capture", 32'h1, irq);
        wr(REG_CTL, 32'h0);
        wr(REG_ICR, 32'h7F);
        $display("test capture done");
    endtask
    task t_rtc;
        wr(REG_CFG, 32'h4);
        wr(REG_LOAD_A, 32'h0);
        wr(REG_MATCH_A, 32'h2);
        wr(REG_IMR, 32'h8);
        wr(REG_CTL, 32'h1);
        repeat (8) begin
            rtc_clk_in <= 1'h1;
            repeat (5) @(posedge clock);
            rtc_clk_in <= 1'h0;
            repeat (5) @(posedge clock);
        end
        rchk("seconds", REG_VALUE_A, 32'h2);
        rd(REG_RIS);
        chk("clock match", 32'h1, v[INT_RTC]);
        $display("test rtc done");
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the whole run needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'h1;
        @(posedge clock);
        t_reset;
        t_wait_oneshot;
        t_periodic;
        t_pwm;
        t_capture;
        t_rtc;
        give_verdict;
    end
endmodule // dual_half_gp_timer_tb
